// ==== design/code_map_cfg.svh ====
// Offsets, field positions, reset values and decode constants of the code-map block
`ifndef CODE_MAP_CFG_SVH
`define CODE_MAP_CFG_SVH

`define MAP_CONTROL_OFS 16'h0fde
`define MAP_STATE_OFS 16'h0fdf
`define MAP_COMMIT_OFS 16'h0fdd
`define MAP_RESET_FLAG_OFS 16'h0fdc
`define MAP_CONTROL_RST 8'h00
`define MAP_BIT_RESET_DIS 0
`define MAP_BIT_RAM_CODE 1
`define MAP_BIT_VEC_RAM 2
`define MAP_KEY_MAPPING 8'hd4
`define MAP_KEY_RESET_DIS 8'hb2
`define MAP_KEY_RESET_FLAG 8'h71
`define RAM_CODE_LO 16'h0040
`define RAM_CODE_HI 16'h083f
`define VCALL_ROM_LO 16'hffa0
`define VCALL_ROM_HI 16'hffbf
`define VINT_ROM_LO 16'hffcc
`define VINT_ROM_HI 16'hffff
`define VCALL_RAM_LO 16'h01a0
`define VCALL_RAM_HI 16'h01bf
`define VINT_RAM_LO 16'h01cc
`define VINT_RAM_HI 16'h01fd
`define LOADER_LO 16'h1000
`define LOADER_HI_NORMAL 16'h17ff
`define LOADER_HI_SERIAL 16'h1fff
`define TRAP_OPCODE_RST 8'hff

`endif

// ==== design/code_map_pkg.sv ====
// Types shared by the code-map block
package code_map_pkg;
	typedef enum logic [1:0] {
		SRC_FLASH = 2'b00,
		SRC_RAM = 2'b01,
		SRC_LOADER = 2'b10,
		SRC_TRAP = 2'b11
	} fetch_src_t;
	typedef logic [15:0] addr_t;
	typedef logic [7:0] byte_t;
endpackage : code_map_pkg

// ==== design/code_map_if.sv ====
// Committed mapping bits and synchronised mode pins passed from the register file to the fetch decoder
`timescale 1ns/1ns
`default_nettype none
interface code_map_if;
	logic ram_in_code;
	logic vec_ram;
	logic loader_map;
	logic serial_mode;
	modport regs (output ram_in_code, output vec_ram, output loader_map, output serial_mode);
	modport dec (input ram_in_code, input vec_ram, input loader_map, input serial_mode);
endinterface : code_map_if
`default_nettype wire

// ==== design/code_fetch_decode.sv ====
// Code-space fetch decoder: picks the source of each instruction fetch
`timescale 1ns/1ns
`default_nettype none
`include "code_map_cfg.svh"
module code_fetch_decode (
	input wire logic sys_clk,
	input wire logic rst,
	code_map_if.dec map,
	input wire code_map_pkg::addr_t fetch_addr,
	input wire logic fetch_req,
	output code_map_pkg::fetch_src_t fetch_src,
	output logic vec_in_ram,
	output logic fetch_valid
);
	import code_map_pkg::*;

	fetch_src_t src_d;
	logic vec_d;
	logic ram_hit;
	logic ld_hi;

	always_comb begin
		ram_hit = (fetch_addr >= `RAM_CODE_LO) && (fetch_addr <= `RAM_CODE_HI);
		// Serial mode sees the whole loader, otherwise only its lower 2 KB
		ld_hi = (fetch_addr <= (map.serial_mode ? `LOADER_HI_SERIAL : `LOADER_HI_NORMAL));
		src_d = SRC_FLASH;
		if (ram_hit) begin
			if (map.ram_in_code || map.serial_mode) begin
				src_d = SRC_RAM;
			end else begin
				src_d = SRC_TRAP;
			end
		end else if (map.loader_map && fetch_addr >= `LOADER_LO && ld_hi) begin
			src_d = SRC_LOADER;
		end
		if (map.vec_ram) begin
			vec_d = ((fetch_addr >= `VCALL_RAM_LO) && (fetch_addr <= `VCALL_RAM_HI))
				|| ((fetch_addr >= `VINT_RAM_LO) && (fetch_addr <= `VINT_RAM_HI));
		end else begin
			vec_d = ((fetch_addr >= `VCALL_ROM_LO) && (fetch_addr <= `VCALL_ROM_HI))
				|| (fetch_addr >= `VINT_ROM_LO);
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			fetch_src <= SRC_FLASH;
			vec_in_ram <= 1'b0;
			fetch_valid <= 1'b0;
		end else begin
			fetch_src <= src_d;
			vec_in_ram <= vec_d;
			fetch_valid <= fetch_req;
		end
	end
endmodule : code_fetch_decode
`default_nettype wire

// ==== design/code_area_ram_remap.sv ====
// Code-space mapping control: registers, commit key and fetch decode
//
// Notes on behaviour
// - Fetch and data addresses are separate 64 KB spaces, decoded apart.
// - After reset outside serial mode RAM is reachable by data access only, not by fetch.
// - Committed RAM-in-code set: fetches 0x0040..0x083F come from RAM.
// - A written RAM-in-code bit acts only after key 0xd4 commits it.
// - Vector select 0: call vectors 0xffa0..0xffbf, interrupts 0xffcc..0xffff.
// - Vector select 1: call vectors 0x01a0..0x01bf, interrupts 0x01cc..0x01fd.
// - Serial programming mode always maps RAM into the code space.
// - Unmapped RAM window fetches return the software trap opcode.
// - Outside serial mode only the lower 2 KB of loader ROM decode.
// - Control bits 7..3 read zero; bits 2..0 read/write, reset zero.
// - Commit register is write-only; 0xd4 commits mapping; 0xb2 reset disable and 0x71 flag clear act only in normal mode at fc/4; others ignored.
// - Status bits 1 and 2 show committed RAM and vector settings.
// - Status bits 7..3 read zero.
//
// Strobed register access was decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "code_map_cfg.svh"
module code_area_ram_remap (
	input wire logic sys_clk,
	input wire logic rst,
	input wire code_map_pkg::addr_t reg_addr,
	input wire code_map_pkg::byte_t reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output code_map_pkg::byte_t reg_rdata,
	input wire logic serial_prog_pin,
	input wire logic loader_map_en,
	input wire logic normal_mode,
	input wire logic gear_is_div4,
	input wire code_map_pkg::addr_t fetch_addr,
	input wire logic fetch_req,
	output code_map_pkg::fetch_src_t fetch_src,
	output logic vec_in_ram,
	output logic fetch_valid,
	input wire code_map_pkg::addr_t data_addr,
	output logic data_ram_sel,
	output code_map_pkg::byte_t software_trap_opcode,
	output logic reset_disable,
	output logic reset_flag_clear
);
	import code_map_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	logic serial_meta_q;
	logic serial_q;
	logic ldr_meta_q;
	logic ldr_q;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			serial_meta_q <= 1'b0;
			serial_q <= 1'b0;
			ldr_meta_q <= 1'b0;
			ldr_q <= 1'b0;
		end else begin
			serial_meta_q <= serial_prog_pin;
			serial_q <= serial_meta_q;
			ldr_meta_q <= loader_map_en;
			ldr_q <= ldr_meta_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pending control register

	byte_t ctrl_q;
	logic ctrl_wr;
	logic key_wr;
	logic flag_wr;

	assign ctrl_wr = reg_wr && (reg_addr == `MAP_CONTROL_OFS);
	assign key_wr = reg_wr && (reg_addr == `MAP_COMMIT_OFS);
	assign flag_wr = reg_wr && (reg_addr == `MAP_RESET_FLAG_OFS);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ctrl_q <= `MAP_CONTROL_RST;
		end else if (ctrl_wr) begin
			ctrl_q <= {5'h00, reg_wdata[2:0]};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Committed mapping, updated on the key write itself

	logic ram_code_q;
	logic vec_ram_q;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ram_code_q <= 1'b0;
			vec_ram_q <= 1'b0;
		end else if (key_wr && reg_wdata == `MAP_KEY_MAPPING) begin
			ram_code_q <= ctrl_q[`MAP_BIT_RAM_CODE];
			vec_ram_q <= ctrl_q[`MAP_BIT_VEC_RAM];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Reset-disable and reset flag clear keys

	logic rst_dis_q;
	logic flag_pend_q;
	logic flag_clr_q;
	logic gear_ok;

	// Commit only when timing is safe; otherwise the effect could land late
	assign gear_ok = normal_mode && gear_is_div4;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rst_dis_q <= 1'b0;
		end else if (key_wr && reg_wdata == `MAP_KEY_RESET_DIS && gear_ok) begin
			rst_dis_q <= ctrl_q[`MAP_BIT_RESET_DIS];
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			flag_pend_q <= 1'b0;
		end else if (flag_wr) begin
			flag_pend_q <= reg_wdata[0];
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			flag_clr_q <= 1'b0;
		end else begin
			flag_clr_q <= key_wr && reg_wdata == `MAP_KEY_RESET_FLAG
				&& gear_ok && flag_pend_q;
		end
	end

	assign reset_disable = rst_dis_q;
	assign reset_flag_clear = flag_clr_q;

	////////////////////////////////////////////////////////////////////////
	// Read path; the commit register reads as zero

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				`MAP_CONTROL_OFS: reg_rdata <= ctrl_q;
				`MAP_STATE_OFS: reg_rdata <= {5'h00, vec_ram_q, ram_code_q, rst_dis_q};
				`MAP_RESET_FLAG_OFS: reg_rdata <= {7'h00, flag_pend_q};
				default: reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Data space decode, independent of the fetch mapping

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			data_ram_sel <= 1'b0;
		end else begin
			data_ram_sel <= (data_addr >= `RAM_CODE_LO) && (data_addr <= `RAM_CODE_HI);
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			software_trap_opcode <= `TRAP_OPCODE_RST;
		end else begin
			software_trap_opcode <= `TRAP_OPCODE_RST;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Fetch decode

	code_map_if map ();

	assign map.ram_in_code = ram_code_q;
	assign map.vec_ram = vec_ram_q;
	assign map.loader_map = ldr_q || serial_q;
	assign map.serial_mode = serial_q;

	code_fetch_decode u_dec (
		.sys_clk(sys_clk),
		.rst(rst),
		.map(map),
		.fetch_addr(fetch_addr),
		.fetch_req(fetch_req),
		.fetch_src(fetch_src),
		.vec_in_ram(vec_in_ram),
		.fetch_valid(fetch_valid)
	);
endmodule : code_area_ram_remap
`default_nettype wire

// ==== verification/code_area_ram_remap_sva.sv ====
// Port assertions for the code-map block
`timescale 1ns/1ns
`default_nettype none
module code_area_ram_remap_sva (
	input wire logic sys_clk,
	input wire logic rst,
	input wire code_map_pkg::addr_t reg_addr,
	input wire logic reg_rd,
	input wire code_map_pkg::byte_t reg_rdata,
	input wire logic serial_prog_pin,
	input wire code_map_pkg::addr_t fetch_addr,
	input wire logic fetch_req,
	input wire code_map_pkg::fetch_src_t fetch_src,
	input wire logic vec_in_ram,
	input wire code_map_pkg::addr_t data_addr,
	input wire logic data_ram_sel,
	input wire code_map_pkg::byte_t software_trap_opcode
);
	import code_map_pkg::*;
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	trap_value_a: assert property (software_trap_opcode == 8'hff)
		else $error("trap opcode not constant");
	data_window_a: assert property (!$past(rst) |->
		data_ram_sel == ($past(data_addr) inside {[16'h0040:16'h083f]}))
		else $error("data RAM select wrong");
	idle_rdata_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside read cycle");
	upper_zero_a: assert property ($past(reg_rd) &&
		($past(reg_addr) inside {16'h0fde, 16'h0fdf}) |-> reg_rdata[7:3] == 5'h00)
		else $error("upper control bits not zero");
	ram_window_a: assert property (fetch_req &&
		(fetch_addr inside {[16'h0040:16'h083f]}) |=> fetch_src inside {SRC_RAM, SRC_TRAP})
		else $error("RAM window fetch from wrong source");
	serial_ram_a: assert property (serial_prog_pin[*4] ##1 (serial_prog_pin &&
		fetch_req && (fetch_addr inside {[16'h0040:16'h083f]})) |=> fetch_src == SRC_RAM)
		else $error("serial mode RAM not mapped");
	loader_cap_a: assert property ((!serial_prog_pin)[*4] ##1 (fetch_req &&
		(fetch_addr inside {[16'h1800:16'h1fff]})) |=> fetch_src != SRC_LOADER)
		else $error("upper loader half decoded");
	vec_range_a: assert property (fetch_req && !(fetch_addr inside {
		[16'h01a0:16'h01bf], [16'h01cc:16'h01fd], [16'hffa0:16'hffbf], [16'hffcc:16'hffff]})
		|=> !vec_in_ram)
		else $error("vector flag outside vector tables");
endmodule : code_area_ram_remap_sva
bind code_area_ram_remap code_area_ram_remap_sva chk_u (.*);
`default_nettype wire

// ==== verification/cpu_fetch_model.sv ====
// CPU fetch and data access model driving the code-map block
`timescale 1ns/1ns
`default_nettype none
module cpu_fetch_model (
	input wire logic sys_clk,
	output code_map_pkg::addr_t fetch_addr,
	output logic fetch_req,
	output code_map_pkg::addr_t data_addr
);
	import code_map_pkg::*;
	initial begin
		fetch_addr = 16'h0000;
		fetch_req = 1'b0;
		data_addr = 16'h0000;
	end
	// Address inverted after use so a stale value cannot pass as a new one
	task automatic fetch(input addr_t a);
		@(posedge sys_clk);
		fetch_addr <= a;
		data_addr <= a;
		fetch_req <= 1'b1;
		@(posedge sys_clk);
		fetch_req <= 1'b0;
		fetch_addr <= ~a;
		data_addr <= ~a;
		@(negedge sys_clk);
	endtask : fetch
endmodule : cpu_fetch_model
`default_nettype wire

// ==== verification/code_area_ram_remap_test.sv ====
// Self-checking bench of the code-map block
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin err_count++; \
	$display("unexpected %s exp %h got %h", n, e, s); end end
module code_area_ram_remap_test;
	import code_map_pkg::*;
	typedef struct {addr_t a; fetch_src_t s; logic v;} row_t;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	addr_t reg_addr = 16'h0000;
	byte_t reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic serial_prog_pin = 1'b0;
	logic loader_map_en = 1'b0;
	logic normal_mode = 1'b0;
	logic gear_is_div4 = 1'b0;
	addr_t fetch_addr;
	addr_t data_addr;
	logic fetch_req;
	byte_t reg_rdata;
	byte_t software_trap_opcode;
	fetch_src_t fetch_src;
	logic vec_in_ram;
	logic fetch_valid;
	logic data_ram_sel;
	logic reset_disable;
	logic reset_flag_clear;
	int err_count = 0;
	int checks = 0;
	row_t rows [8] = '{'{16'h0040, SRC_TRAP, 1'b0}, '{16'h083f, SRC_TRAP, 1'b0},
		'{16'h01a0, SRC_TRAP, 1'b0}, '{16'h8000, SRC_FLASH, 1'b0},
		'{16'hffa0, SRC_FLASH, 1'b1}, '{16'hffbf, SRC_FLASH, 1'b1},
		'{16'hffcb, SRC_FLASH, 1'b0}, '{16'hffff, SRC_FLASH, 1'b1}};
	always #2 sys_clk = ~sys_clk;
	code_area_ram_remap dut_u (.*);
	cpu_fetch_model cpu_u (.*);
	////////////////////////////////////////////////////////////////////////////////
	task automatic wr(input addr_t a, input byte_t d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
	endtask : wr
	task automatic rd(input addr_t a, input byte_t e);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		`CHK("read data", e, reg_rdata)
	endtask : rd
	task automatic ft(input addr_t a, input fetch_src_t s, input logic v);
		cpu_u.fetch(a);
		`CHK("fetch source", s, fetch_src)
		`CHK("vector flag", v, vec_in_ram)
		`CHK("data select", (a >= 16'h0040 && a <= 16'h083f), data_ram_sel)
		`CHK("fetch valid", 1'b1, fetch_valid)
	endtask : ft
	task automatic summarize;
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : summarize
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#20000;
		err_count++;
		summarize();
	end
	initial begin
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			ft(rows[i].a, rows[i].s, rows[i].v);
		end
		// Last row fetched 0xffff, so the data side must not select RAM
		`CHK("data select", 1'b0, data_ram_sel)
		rd(16'h0fde, 8'h00);
		rd(16'h0fdd, 8'h00);
		wr(16'h0fde, 8'hff);
		rd(16'h0fde, 8'h07);
		rd(16'h0fdf, 8'h00);
		ft(16'h0040, SRC_TRAP, 1'b0);
		wr(16'h0fdd, 8'h55);
		rd(16'h0fdf, 8'h00);
		wr(16'h0fde, 8'h06);
		wr(16'h0fdd, 8'hd4);
		ft(16'h0040, SRC_RAM, 1'b0);
		ft(16'h01a0, SRC_RAM, 1'b1);
		ft(16'h01fd, SRC_RAM, 1'b1);
		ft(16'h01fe, SRC_RAM, 1'b0);
		ft(16'hffa0, SRC_FLASH, 1'b0);
		wr(16'h0fde, 8'h00);
		rd(16'h0fdf, 8'h06);
		// Reset-disable key is refused until the gear is at fc/4
		@(posedge sys_clk);
		normal_mode <= 1'b1;
		wr(16'h0fde, 8'h01);
		wr(16'h0fdd, 8'hb2);
		@(negedge sys_clk);
		`CHK("reset disable", 1'b0, reset_disable)
		@(posedge sys_clk);
		gear_is_div4 <= 1'b1;
		wr(16'h0fdd, 8'hb2);
		rd(16'h0fdf, 8'h07);
		`CHK("reset disable", 1'b1, reset_disable)
		wr(16'h0fdc, 8'h01);
		wr(16'h0fdd, 8'h71);
		@(negedge sys_clk);
		`CHK("flag clear", 1'b1, reset_flag_clear)
		@(negedge sys_clk);
		`CHK("flag clear", 1'b0, reset_flag_clear)
		// Second reset with serial mode already pending, as at a loader boot
		@(posedge sys_clk);
		rst <= 1'b1;
		serial_prog_pin <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		rd(16'h0fdf, 8'h00);
		`CHK("fetch valid", 1'b0, fetch_valid)
		`CHK("reset disable", 1'b0, reset_disable)
		rd(16'h0fde, 8'h00);
		ft(16'h0040, SRC_RAM, 1'b0);
		ft(16'h1fff, SRC_LOADER, 1'b0);
		// A loader keeps the vectors in RAM, never committing select 0
		wr(16'h0fde, 8'h06);
		wr(16'h0fdd, 8'hd4);
		ft(16'h01cc, SRC_RAM, 1'b1);
		@(posedge sys_clk);
		serial_prog_pin <= 1'b0;
		loader_map_en <= 1'b1;
		repeat (4) @(posedge sys_clk);
		ft(16'h1000, SRC_LOADER, 1'b0);
		cpu_u.fetch(16'h1800);
		`CHK("loader half", 1'b1, fetch_src != SRC_LOADER)
		summarize();
	end
endmodule : code_area_ram_remap_test
`default_nettype wire
